//--- exec_consts.vh
// constants of the branch, bit, shift, flag and load execution unit
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH

// wishbone register byte offsets
`define OFS_FLAGS 8'h00
`define OFS_PC 8'h04
`define OFS_EXEC_STATUS 8'h08
`define OFS_RETIRED 8'h0c
`define GPR_WINDOW_BIT 7

// reset values
`define RST_FLAGS 8'h00
`define RST_PC 16'h0000
`define RST_GPR 8'h00

// status flag bit positions
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// pointer pair register indices
`define PTR_LO_IDX 5'h1a
`define PTR_HI_IDX 5'h1b

// decoded operation codes
`define OP_NOP 5'h00
`define OP_BR_BIT_ON 5'h01
`define OP_BR_BIT_OFF 5'h02
`define OP_BR_UGE 5'h03
`define OP_BR_ULT 5'h04
`define OP_BR_NEG 5'h05
`define OP_BR_NNEG 5'h06
`define OP_BR_SGE 5'h07
`define OP_BR_SLT 5'h08
`define OP_BR_HON 5'h09
`define OP_BR_HOFF 5'h0a
`define OP_BR_TON 5'h0b
`define OP_BR_TOFF 5'h0c
`define OP_BR_VON 5'h0d
`define OP_BR_VOFF 5'h0e
`define OP_BR_ION 5'h0f
`define OP_BR_IOFF 5'h10
`define OP_SET_IO 5'h11
`define OP_CLR_IO 5'h12
`define OP_SHL 5'h13
`define OP_SHR 5'h14
`define OP_ROTR 5'h15
`define OP_SAR 5'h16
`define OP_FLAG_ON 5'h17
`define OP_FLAG_OFF 5'h18
`define OP_TSTORE 5'h19
`define OP_TLOAD 5'h1a
`define OP_COPY 5'h1b
`define OP_COPYW 5'h1c
`define OP_CONST 5'h1d
`define OP_PLOAD_INC 5'h1e
`define OP_PLOAD_DEC 5'h1f

`endif

//--- shift_unit.v
// shift and rotate datapath with flag results
`timescale 1ns/1ps
`include "exec_consts.vh"
module shift_unit (
  // operation and operand
  input wire [4:0] op_i,
  input wire [7:0] val_i,
  input wire carry_i,
  // result and flags
  output reg [7:0] res_o,
  output reg carry_o,
  output wire zero_o,
  output wire neg_o,
  output wire ovf_o
);
  always @* begin
    res_o = val_i;
    carry_o = carry_i;
    case (op_i)
      `OP_SHL: begin
        res_o = {val_i[6:0], 1'b0};
        carry_o = val_i[7];
      end
      `OP_SHR: begin
        res_o = {1'b0, val_i[7:1]};
        carry_o = val_i[0];
      end
      `OP_ROTR: begin
        res_o = {carry_i, val_i[7:1]};
        carry_o = val_i[0];
      end
      `OP_SAR: begin
        res_o = {val_i[7], val_i[7:1]};
        carry_o = val_i[0];
      end
      default: begin
        res_o = val_i;
        carry_o = carry_i;
      end
    endcase
  end

  assign zero_o = (res_o == 8'h00);
  assign neg_o = res_o[7];
  // overflow is negative xor carry after the shift
  assign ovf_o = res_o[7] ^ carry_o;
endmodule // shift_unit

//--- branch_cond.v
// condition evaluation for the conditional branches
`timescale 1ns/1ps
`include "exec_consts.vh"
module branch_cond (
  // operation and flags
  input wire [4:0] op_i,
  input wire [2:0] bit_i,
  input wire [7:0] flags_i,
  // decision
  output reg is_branch_o,
  output wire taken_o
);
  reg cond;
  reg want;

  always @* begin
    is_branch_o = 1'b1;
    cond = 1'b0;
    want = 1'b1;
    case (op_i)
      `OP_BR_BIT_ON: begin cond = flags_i[bit_i]; want = 1'b1; end
      `OP_BR_BIT_OFF: begin cond = flags_i[bit_i]; want = 1'b0; end
      `OP_BR_UGE: begin cond = flags_i[`FLAG_C]; want = 1'b0; end
      `OP_BR_ULT: begin cond = flags_i[`FLAG_C]; want = 1'b1; end
      `OP_BR_NEG: begin cond = flags_i[`FLAG_N]; want = 1'b1; end
      `OP_BR_NNEG: begin cond = flags_i[`FLAG_N]; want = 1'b0; end
      `OP_BR_SGE: begin cond = flags_i[`FLAG_N] ^ flags_i[`FLAG_V]; want = 1'b0; end
      `OP_BR_SLT: begin cond = flags_i[`FLAG_N] ^ flags_i[`FLAG_V]; want = 1'b1; end
      `OP_BR_HON: begin cond = flags_i[`FLAG_H]; want = 1'b1; end
      `OP_BR_HOFF: begin cond = flags_i[`FLAG_H]; want = 1'b0; end
      `OP_BR_TON: begin cond = flags_i[`FLAG_T]; want = 1'b1; end
      `OP_BR_TOFF: begin cond = flags_i[`FLAG_T]; want = 1'b0; end
      `OP_BR_VON: begin cond = flags_i[`FLAG_V]; want = 1'b1; end
      `OP_BR_VOFF: begin cond = flags_i[`FLAG_V]; want = 1'b0; end
      `OP_BR_ION: begin cond = flags_i[`FLAG_I]; want = 1'b1; end
      `OP_BR_IOFF: begin cond = flags_i[`FLAG_I]; want = 1'b0; end
      default: begin
        is_branch_o = 1'b0;
        cond = 1'b0;
        want = 1'b1;
      end
    endcase
  end

  assign taken_o = is_branch_o & (cond == want);
endmodule // branch_cond

//--- branch_bit_move_exec.v
// execution unit for branches, bit moves, shifts, flag ops and pointer loads
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "exec_consts.vh"
module branch_bit_move_exec (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // decoded instruction
  input wire instr_valid_i,
  output wire instr_ready_o,
  input wire [4:0] instr_op_i,
  input wire [4:0] instr_rd_i,
  input wire [4:0] instr_rr_i,
  input wire [2:0] instr_bit_i,
  input wire [7:0] instr_k_i,
  // io register port
  output wire [5:0] io_addr_o,
  output wire io_rd_o,
  output wire io_wr_o,
  output wire [7:0] io_wdata_o,
  input wire [7:0] io_rdata_i,
  // data memory read port
  output wire [15:0] dmem_addr_o,
  output wire dmem_rd_o,
  input wire [7:0] dmem_rdata_i,
  // core state
  output wire [15:0] pc_o,
  output wire [7:0] status_flags_o
);
  localparam [3:0] S_EXEC = 4'b0001;
  localparam [3:0] S_BRANCH2 = 4'b0010;
  localparam [3:0] S_IO2 = 4'b0100;
  localparam [3:0] S_LOAD2 = 4'b1000;

  // architectural state
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [15:0] pc_q;
  reg [15:0] pc_d;
  reg [7:0] flags_q;
  reg [7:0] flags_d;
  reg [7:0] gpr_q [0:31];

  // second-cycle bookkeeping
  reg [2:0] io_bit_q;
  reg io_set_q;
  reg [4:0] load_rd_q;
  reg io_rd_q;
  reg io_wr_q;
  reg [5:0] io_addr_q;
  reg [7:0] io_wdata_q;
  reg dmem_rd_q;
  reg [15:0] dmem_addr_q;
  reg last_taken_q;
  reg [15:0] retired_q;

  // bus slave state
  reg wb_ack_q;
  reg [31:0] wb_dat_q;
  reg [31:0] rd_mux;

  // register file write ports
  reg pa_en;
  reg [4:0] pa_idx;
  reg [7:0] pa_dat;
  reg pb_en;
  reg [4:0] pb_idx;
  reg [7:0] pb_dat;
  reg ptr_en;
  reg [15:0] ptr_dat;
  reg [7:0] tload_val;
  reg [7:0] io_mod;

  wire accept = instr_valid_i & (state_q == S_EXEC);
  wire [7:0] rd_val = gpr_q[instr_rd_i];
  wire [7:0] rr_val = gpr_q[instr_rr_i];
  wire [4:0] pair_dst = {instr_rd_i[4:1], 1'b0};
  wire [4:0] pair_src = {instr_rr_i[4:1], 1'b0};
  wire [7:0] pair_lo = gpr_q[pair_src];
  wire [7:0] pair_hi = gpr_q[pair_src | 5'h01];
  wire [15:0] ptr_val = {gpr_q[`PTR_HI_IDX], gpr_q[`PTR_LO_IDX]};
  wire [15:0] pc_inc = pc_q + 16'h0001;
  wire [15:0] br_offset = {{9{instr_k_i[6]}}, instr_k_i[6:0]};
  wire [15:0] pc_branch = pc_inc + br_offset;

  // helpers
  wire br_is;
  wire br_taken;
  wire [7:0] sh_res;
  wire sh_c;
  wire sh_z;
  wire sh_n;
  wire sh_v;

  branch_cond u_branch_cond (
    .op_i(instr_op_i),
    .bit_i(instr_bit_i),
    .flags_i(flags_q),
    .is_branch_o(br_is),
    .taken_o(br_taken)
  );

  shift_unit u_shift_unit (
    .op_i(instr_op_i),
    .val_i(rd_val),
    .carry_i(flags_q[`FLAG_C]),
    .res_o(sh_res),
    .carry_o(sh_c),
    .zero_o(sh_z),
    .neg_o(sh_n),
    .ovf_o(sh_v)
  );

  // execute decision
  always @* begin
    state_d = state_q;
    pc_d = pc_q;
    flags_d = flags_q;
    pa_en = 1'b0;
    pa_idx = instr_rd_i;
    pa_dat = 8'h00;
    pb_en = 1'b0;
    pb_idx = instr_rd_i;
    pb_dat = 8'h00;
    ptr_en = 1'b0;
    ptr_dat = ptr_val;
    tload_val = rd_val;
    tload_val[instr_bit_i] = flags_q[`FLAG_T];
    case (state_q)
      S_EXEC: begin
        if (accept) begin
          pc_d = pc_inc;
          if (br_is) begin
            if (br_taken) begin
              pc_d = pc_branch;
              state_d = S_BRANCH2;
            end
          end else begin
            case (instr_op_i)
              `OP_SET_IO: state_d = S_IO2;
              `OP_CLR_IO: state_d = S_IO2;
              `OP_SHL, `OP_SHR, `OP_ROTR, `OP_SAR: begin
                pa_en = 1'b1;
                pa_dat = sh_res;
                flags_d[`FLAG_C] = sh_c;
                flags_d[`FLAG_Z] = sh_z;
                flags_d[`FLAG_N] = sh_n;
                flags_d[`FLAG_V] = sh_v;
              end
              `OP_FLAG_ON: flags_d[instr_bit_i] = 1'b1;
              `OP_FLAG_OFF: flags_d[instr_bit_i] = 1'b0;
              `OP_TSTORE: flags_d[`FLAG_T] = rr_val[instr_bit_i];
              `OP_TLOAD: begin
                pa_en = 1'b1;
                pa_dat = tload_val;
              end
              `OP_COPY: begin
                pa_en = 1'b1;
                pa_dat = rr_val;
              end
              `OP_COPYW: begin
                pa_en = 1'b1;
                pa_idx = pair_dst;
                pa_dat = pair_lo;
                pb_en = 1'b1;
                pb_idx = pair_dst | 5'h01;
                pb_dat = pair_hi;
              end
              `OP_CONST: begin
                pa_en = 1'b1;
                pa_dat = instr_k_i;
              end
              `OP_PLOAD_INC: begin
                ptr_en = 1'b1;
                ptr_dat = ptr_val + 16'h0001;
                state_d = S_LOAD2;
              end
              `OP_PLOAD_DEC: begin
                ptr_en = 1'b1;
                ptr_dat = ptr_val - 16'h0001;
                state_d = S_LOAD2;
              end
              default: state_d = S_EXEC;
            endcase
          end
        end
      end
      S_BRANCH2: state_d = S_EXEC;
      S_IO2: state_d = S_EXEC;
      S_LOAD2: begin
        pa_en = 1'b1;
        pa_idx = load_rd_q;
        pa_dat = dmem_rdata_i;
        state_d = S_EXEC;
      end
      default: state_d = S_EXEC;
    endcase
  end

  // io read-modify-write value
  always @* begin
    io_mod = io_rdata_i;
    io_mod[io_bit_q] = io_set_q;
  end

  // wishbone decode
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wb_commit = wb_req & wb_we_i & wb_ack_q;
  wire gpr_hit = wb_adr_i[`GPR_WINDOW_BIT];
  wire [4:0] gpr_bus_idx = wb_adr_i[6:2];
  wire exec_owns = accept | (state_q != S_EXEC);
  wire flags_bus_wr = wb_commit & ~gpr_hit & (wb_adr_i == `OFS_FLAGS) & wb_sel_i[0];
  wire pc_bus_wr = wb_commit & ~gpr_hit & (wb_adr_i == `OFS_PC);

  always @* begin
    rd_mux = 32'h00000000;
    if (gpr_hit) begin
      rd_mux = {24'h000000, gpr_q[gpr_bus_idx]};
    end else begin
      case (wb_adr_i)
        `OFS_FLAGS: rd_mux = {24'h000000, flags_q};
        `OFS_PC: rd_mux = {16'h0000, pc_q};
        `OFS_EXEC_STATUS: rd_mux = {30'h0, last_taken_q, (state_q != S_EXEC)};
        `OFS_RETIRED: rd_mux = {16'h0000, retired_q};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h00000000;
    end else begin
      wb_ack_q <= wb_req & ~wb_ack_q;
      if (wb_req & ~wb_ack_q) begin
        wb_dat_q <= rd_mux;
      end
    end
  end

  // core registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_EXEC;
      pc_q <= `RST_PC;
      flags_q <= `RST_FLAGS;
      last_taken_q <= 1'b0;
      retired_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (exec_owns) begin
        pc_q <= pc_d;
        flags_q <= flags_d;
      end else begin
        if (pc_bus_wr) begin
          pc_q[7:0] <= wb_sel_i[0] ? wb_dat_i[7:0] : pc_q[7:0];
          pc_q[15:8] <= wb_sel_i[1] ? wb_dat_i[15:8] : pc_q[15:8];
        end
        if (flags_bus_wr) begin
          flags_q <= wb_dat_i[7:0];
        end
      end
      if (accept) begin
        last_taken_q <= br_taken;
        retired_q <= retired_q + 16'h0001;
      end
    end
  end

  // io and data memory strobes
  always @(posedge clk_i) begin
    if (rst_i) begin
      io_rd_q <= 1'b0;
      io_wr_q <= 1'b0;
      io_addr_q <= 6'h00;
      io_wdata_q <= 8'h00;
      io_bit_q <= 3'h0;
      io_set_q <= 1'b0;
      dmem_rd_q <= 1'b0;
      dmem_addr_q <= 16'h0000;
      load_rd_q <= 5'h00;
    end else begin
      io_wr_q <= 1'b0;
      io_rd_q <= 1'b0;
      dmem_rd_q <= 1'b0;
      if (accept & ~br_is & ((instr_op_i == `OP_SET_IO) | (instr_op_i == `OP_CLR_IO))) begin
        io_addr_q <= instr_k_i[5:0];
        io_bit_q <= instr_bit_i;
        io_set_q <= (instr_op_i == `OP_SET_IO);
        io_rd_q <= 1'b1;
      end
      if (state_q == S_IO2) begin
        io_wdata_q <= io_mod;
        io_wr_q <= 1'b1;
      end
      if (accept & ~br_is & (instr_op_i == `OP_PLOAD_INC)) begin
        dmem_addr_q <= ptr_val;
        dmem_rd_q <= 1'b1;
        load_rd_q <= instr_rd_i;
      end
      if (accept & ~br_is & (instr_op_i == `OP_PLOAD_DEC)) begin
        dmem_addr_q <= ptr_dat;
        dmem_rd_q <= 1'b1;
        load_rd_q <= instr_rd_i;
      end
    end
  end

  // working registers, execution writes win over the bus
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_gpr
      always @(posedge clk_i) begin
        if (rst_i) begin
          gpr_q[gi] <= `RST_GPR;
        end else if (pa_en && (pa_idx == gi)) begin
          gpr_q[gi] <= pa_dat;
        end else if (pb_en && (pb_idx == gi)) begin
          gpr_q[gi] <= pb_dat;
        end else if (ptr_en && (gi == `PTR_LO_IDX)) begin
          gpr_q[gi] <= ptr_dat[7:0];
        end else if (ptr_en && (gi == `PTR_HI_IDX)) begin
          gpr_q[gi] <= ptr_dat[15:8];
        end else if (wb_commit && gpr_hit && wb_sel_i[0] && (gpr_bus_idx == gi)) begin
          gpr_q[gi] <= wb_dat_i[7:0];
        end
      end
    end
  endgenerate

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;
  assign instr_ready_o = (state_q == S_EXEC);
  assign io_addr_o = io_addr_q;
  assign io_rd_o = io_rd_q;
  assign io_wr_o = io_wr_q;
  assign io_wdata_o = io_wdata_q;
  assign dmem_addr_o = dmem_addr_q;
  assign dmem_rd_o = dmem_rd_q;
  assign pc_o = pc_q;
  assign status_flags_o = flags_q;
endmodule // branch_bit_move_exec

//--- branch_bit_move_exec_assertions.sv
// port assertions for the execution unit
`timescale 1ns/1ps
`include "exec_consts.vh"
module exec_port_checker (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // observed ports
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire instr_valid_i,
  input wire instr_ready_o,
  input wire [4:0] instr_op_i,
  input wire [2:0] instr_bit_i,
  input wire [7:0] instr_k_i,
  input wire io_rd_o,
  input wire io_wr_o,
  input wire [5:0] io_addr_o,
  input wire [7:0] io_wdata_o,
  input wire [7:0] io_rdata_i,
  input wire dmem_rd_o,
  input wire [15:0] pc_o,
  input wire [7:0] status_flags_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire take_w = instr_valid_i && instr_ready_o;
  // zero offset excluded: taken and untaken give the same pc
  wire br_w = instr_op_i >= `OP_BR_BIT_ON && instr_op_i <= `OP_BR_IOFF && instr_k_i[6:0] != 7'h00;
  wire io_w = instr_op_i == `OP_SET_IO || instr_op_i == `OP_CLR_IO;
  wire pload_w = instr_op_i == `OP_PLOAD_INC || instr_op_i == `OP_PLOAD_DEC;
  wire one_w = instr_op_i >= `OP_SHL && instr_op_i <= `OP_CONST;
  a_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("bus ack without request");
  a_branch_timing: assert property (
    take_w && br_w |=> instr_ready_o == (pc_o == $past(pc_o) + 16'h1) && $stable(status_flags_o))
    else $error("branch stall or flags wrong");
  a_flag_set: assert property (
    take_w && instr_op_i == `OP_FLAG_ON
    |=> status_flags_o == ($past(status_flags_o) | (8'h01 << $past(instr_bit_i))))
    else $error("flag set wrong");
  a_flag_clear: assert property (
    take_w && instr_op_i == `OP_FLAG_OFF
    |=> status_flags_o == ($past(status_flags_o) & ~(8'h01 << $past(instr_bit_i))))
    else $error("flag clear wrong");
  a_io_walk: assert property (
    take_w && io_w
    |=> io_rd_o && !instr_ready_o ##1 io_wr_o && instr_ready_o && $stable(io_addr_o))
    else $error("io bit sequence wrong");
  a_io_one_bit: assert property (
    io_wr_o |-> $past(io_rd_o) && $countones(io_wdata_o ^ $past(io_rdata_i)) <= 1)
    else $error("io write alters more than one bit");
  a_load_walk: assert property (
    take_w && pload_w |=> dmem_rd_o && !instr_ready_o ##1 instr_ready_o && !dmem_rd_o)
    else $error("pointer load timing wrong");
  a_single_cycle: assert property (
    take_w && one_w |=> instr_ready_o && pc_o == $past(pc_o) + 16'h1)
    else $error("single-cycle op stalled");
  c_taken: cover property (take_w && br_w ##1 !instr_ready_o);
  c_io: cover property (io_wr_o);
  c_load: cover property (dmem_rd_o);
endmodule // exec_port_checker

//--- branch_bit_move_exec_tb_top.sv
// self-checking bench for the execution unit
`timescale 1ns/1ps
`include "exec_consts.vh"
module branch_bit_move_exec_tb_top;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'hf;
  reg [31:0] wb_dat_i = 32'h0;
  reg instr_valid_i = 1'b0;
  reg [4:0] instr_op_i = 5'h00;
  reg [4:0] instr_rd_i = 5'h00;
  reg [4:0] instr_rr_i = 5'h00;
  reg [2:0] instr_bit_i = 3'h0;
  reg [7:0] instr_k_i = 8'h00;
  reg [7:0] io_rdata_i = 8'h5a;
  reg [7:0] dmem_rdata_i = 8'hc3;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, instr_ready_o, io_rd_o, io_wr_o, dmem_rd_o;
  wire [5:0] io_addr_o;
  wire [7:0] io_wdata_o, status_flags_o;
  wire [15:0] dmem_addr_o, pc_o;
  integer n_mismatch = 0;
  integer n_checks = 0;
  reg [31:0] rdat;
  always #20 clk_i = ~clk_i;
  branch_bit_move_exec u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .instr_valid_i, .instr_ready_o, .instr_op_i,
    .instr_rd_i, .instr_rr_i, .instr_bit_i, .instr_k_i, .io_addr_o, .io_rd_o, .io_wr_o,
    .io_wdata_o, .io_rdata_i, .dmem_addr_o, .dmem_rd_o, .dmem_rdata_i, .pc_o, .status_flags_o);
  task chk(input [31:0] got, input [31:0] exp, input [8*12-1:0] what);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: %0s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask
  task wb(input we, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      #1;
      while (wb_ack_o !== 1'b1) begin
        @(posedge clk_i);
        #1;
      end
      // ack stands in this cycle: data taken at the edge that samples it
      @(posedge clk_i);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task creg(input [4:0] n, input [7:0] e, input [8*12-1:0] what);
    begin
      wb(1'b0, {1'b1, n, 2'b00}, 32'h0);
      chk(rdat, {24'h0, e}, what);
    end
  endtask
  task ex(input [4:0] op, input [4:0] rd, input [4:0] rr, input [2:0] b, input [7:0] k);
    begin
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_op_i <= op;
      instr_rd_i <= rd;
      instr_rr_i <= rr;
      instr_bit_i <= b;
      instr_k_i <= k;
      #1;
      while (instr_ready_o !== 1'b1) begin
        @(posedge clk_i);
        #1;
      end
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
    end
  endtask
  function take(input [4:0] op, input [7:0] f, input [2:0] b);
    reg v;
    begin
      case (op)
        `OP_BR_BIT_ON, `OP_BR_BIT_OFF: v = f[b];
        `OP_BR_UGE, `OP_BR_ULT: v = f[`FLAG_C];
        `OP_BR_NEG, `OP_BR_NNEG: v = f[`FLAG_N];
        `OP_BR_SGE, `OP_BR_SLT: v = f[`FLAG_N] ^ f[`FLAG_V];
        `OP_BR_HON, `OP_BR_HOFF: v = f[`FLAG_H];
        `OP_BR_TON, `OP_BR_TOFF: v = f[`FLAG_T];
        `OP_BR_VON, `OP_BR_VOFF: v = f[`FLAG_V];
        default: v = f[`FLAG_I];
      endcase
      case (op)
        `OP_BR_BIT_OFF, `OP_BR_UGE, `OP_BR_NNEG, `OP_BR_SGE, `OP_BR_HOFF, `OP_BR_TOFF,
        `OP_BR_VOFF, `OP_BR_IOFF: take = !v;
        default: take = v;
      endcase
    end
  endfunction
  task t_branch;
    integer i, j;
    reg [7:0] f;
    reg [15:0] e;
    reg tk;
    begin
      for (i = 1; i <= 16; i = i + 1) begin
        for (j = 0; j < 3; j = j + 1) begin
          f = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'h08;
          wb(1'b1, `OFS_PC, 32'h0100);
          wb(1'b1, `OFS_FLAGS, {24'h0, f});
          tk = take(i[4:0], f, i[2:0]);
          ex(i[4:0], 5'h00, 5'h00, i[2:0], (j == 2) ? 8'h40 : 8'h05);
          e = !tk ? 16'h0101 : (j == 2) ? 16'h00c1 : 16'h0106;
          chk(pc_o, e, "branch pc");
          chk(status_flags_o, f, "branch flag");
          chk(instr_ready_o, !tk, "branch rdy");
        end
      end
    end
  endtask
  task t_flag;
    integer i;
    reg [7:0] e;
    begin
      wb(1'b1, `OFS_FLAGS, 32'h0);
      e = 8'h00;
      for (i = 0; i < 16; i = i + 1) begin
        e[i % 8] = (i < 8);
        ex((i < 8) ? `OP_FLAG_ON : `OP_FLAG_OFF, 5'h00, 5'h00, i[2:0], 8'h00);
        chk(status_flags_o, e, "flag op");
      end
    end
  endtask
  task t_shift;
    integer i;
    reg [7:0] v, r, f;
    reg c, ci;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        ci = i[0];
        v = ci ? 8'h81 : 8'h01;
        c = (i[2:1] == 2'd0) ? v[7] : v[0];
        case (i[2:1])
          2'd0: r = {v[6:0], 1'b0};
          2'd1: r = {1'b0, v[7:1]};
          2'd2: r = {ci, v[7:1]};
          default: r = {v[7], v[7:1]};
        endcase
        wb(1'b1, `OFS_FLAGS, {24'h0, 7'h38, ci});
        ex(`OP_CONST, 5'h10, 5'h00, 3'h0, v);
        ex(`OP_SHL + {3'h0, i[2:1]}, 5'h10, 5'h10, 3'h0, 8'h00);
        f = {4'h7, r[7] ^ c, r[7], r == 8'h00, c};
        chk(status_flags_o, f, "shift flag");
        creg(5'h10, r, "shift data");
      end
    end
  endtask
  task t_move;
    begin
      wb(1'b1, `OFS_FLAGS, 32'h0);
      ex(`OP_CONST, 5'h10, 5'h00, 3'h0, 8'ha5);
      ex(`OP_CONST, 5'h11, 5'h00, 3'h0, 8'h3c);
      ex(`OP_COPY, 5'h02, 5'h11, 3'h0, 8'h00);
      ex(`OP_COPYW, 5'h04, 5'h10, 3'h0, 8'h00);
      ex(`OP_TSTORE, 5'h00, 5'h10, 3'h5, 8'h00);
      chk(status_flags_o, 8'h40, "bit store");
      ex(`OP_TLOAD, 5'h11, 5'h00, 3'h1, 8'h00);
      chk(status_flags_o, 8'h40, "bit load");
      creg(5'h02, 8'h3c, "copy");
      creg(5'h04, 8'ha5, "pair lo");
      creg(5'h05, 8'h3c, "pair hi");
      creg(5'h11, 8'h3e, "bit load");
    end
  endtask
  task t_io;
    integer i;
    begin
      wb(1'b1, `OFS_FLAGS, 32'h0);
      for (i = 0; i < 2; i = i + 1) begin
        ex(i ? `OP_CLR_IO : `OP_SET_IO, 5'h00, 5'h00, i[2:0], 8'h2b);
        chk({io_rd_o, io_addr_o}, 7'h6b, "io read");
        @(posedge clk_i);
        #1;
        chk({io_wr_o, io_wdata_o}, i ? 9'h158 : 9'h15b, "io write");
        chk(status_flags_o, 8'h00, "io flags");
      end
    end
  endtask
  task t_load;
    begin
      wb(1'b1, 8'he8, 32'hff);
      wb(1'b1, 8'hec, 32'h01);
      ex(`OP_PLOAD_INC, 5'h03, 5'h00, 3'h0, 8'h00);
      chk({dmem_rd_o, dmem_addr_o}, 17'h101ff, "inc addr");
      creg(5'h03, 8'hc3, "inc data");
      creg(5'h1a, 8'h00, "inc ptr lo");
      creg(5'h1b, 8'h02, "inc ptr hi");
      ex(`OP_PLOAD_DEC, 5'h04, 5'h00, 3'h0, 8'h00);
      chk({dmem_rd_o, dmem_addr_o}, 17'h101ff, "dec addr");
      creg(5'h04, 8'hc3, "dec data");
      creg(5'h1a, 8'hff, "dec ptr lo");
      creg(5'h1b, 8'h01, "dec ptr hi");
      chk(status_flags_o, 8'h00, "load flags");
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h10, 32'h0);
    chk(rdat, 32'h0, "unmapped");
    chk({pc_o, status_flags_o}, 24'h0, "reset");
    t_branch;
    // last branch of the sweep is taken and the core is idle again
    wb(1'b0, `OFS_EXEC_STATUS, 32'h0);
    chk(rdat, 32'h2, "last taken");
    t_flag;
    t_shift;
    t_move;
    t_io;
    t_load;
    results;
  end
  // hang guard, well beyond the few hundred cycles needed
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    results;
  end
endmodule // branch_bit_move_exec_tb_top
bind branch_bit_move_exec exec_port_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .instr_valid_i, .instr_ready_o, .instr_op_i, .instr_bit_i, .instr_k_i, .io_rd_o,
  .io_wr_o, .io_addr_o, .io_wdata_o, .io_rdata_i, .dmem_rd_o, .pc_o, .status_flags_o);
